//--- tb/esr_rx_asserts.sv
// Checker for the receiver's bus answers, interrupt outputs and wake-up
`timescale 1ns/1ps
module esr_rx_asserts
	import esr_pkg::*;
(
	input wire logic        i_sys_clk, // Clock
	input wire logic        i_rst_n,   // Reset, active low
	input wire logic        i_psel,    // APB select
	input wire logic        i_penable, // APB access
	input wire logic        i_pwrite,  // APB write
	input wire logic [7:0]  i_paddr,   // APB address
	input wire logic [31:0] i_pwdata,  // APB write data
	input wire logic [31:0] o_prdata,  // APB read data
	input wire logic        o_pready,  // APB ready
	input wire logic        o_pslverr, // APB error
	input wire logic        i_sleep,   // Asleep
	input wire logic        i_rx_line, // Receive line
	input wire logic        o_irq_high,// High priority request
	input wire logic        o_irq_low, // Low priority request
	input wire logic        o_wakeup   // Wake pending
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Setup of a read, and a completed read of the data register
	logic setup_rd, rd_rxd;
	assign setup_rd = i_psel && !i_penable && !i_pwrite;
	assign rd_rxd   = i_psel && i_penable && !i_pwrite && i_paddr == ESR_OFS_RXD;

	chk_ready_access: assert property (i_psel && i_penable |-> o_pready)
		else $error("pready low in access");
	chk_unmapped_err: assert property (i_psel && i_penable && i_paddr > ESR_OFS_DIVL |-> o_pslverr)
		else $error("no error on unmapped access");
	chk_upper_zero: assert property (setup_rd |=> o_prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_irq_exclusive: assert property (!(o_irq_high && o_irq_low))
		else $error("both priority requests high");
	chk_irq_flag: assert property (setup_rd && i_paddr == ESR_OFS_PIF && (o_irq_high || o_irq_low)
		|=> o_prdata[ESR_B_RCF])
		else $error("request without receive flag");
	chk_wake_edge: assert property ($rose(o_wakeup) |-> !$past(i_rx_line) && !i_rx_line)
		else $error("wake without falling line");
	chk_wake_hold: assert property (o_wakeup && !rd_rxd |=> o_wakeup)
		else $error("wake cleared without data read");
	chk_wake_rdclr: assert property (rd_rxd && i_rx_line |=> !o_wakeup)
		else $error("wake kept after data read");
	chk_wake_flag: assert property (setup_rd && i_paddr == ESR_OFS_PIF && o_wakeup
		|=> o_prdata[ESR_B_RCF])
		else $error("wake without receive flag");
endmodule

bind esr_rx esr_rx_asserts u_esr_rx_asserts (.i_sys_clk, .i_rst_n, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sleep, .i_rx_line,
	.o_irq_high, .o_irq_low, .o_wakeup);

//--- tb/esr_rx_tb_top.sv
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module async_serial_receiver_wakeup_tb_top
	import esr_pkg::*;
;
	logic        clk, rst_n, psel, penable, pwrite, sleep, rx_line;
	logic        pready, pslverr, irq_hi, irq_lo, wakeup;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	int          n_errors, num_checks;

	esr_rx u_esr_rx (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_sleep(sleep), .i_rx_line(rx_line),
		.o_irq_high(irq_hi), .o_irq_low(irq_lo), .o_wakeup(wakeup));
	esr_tx_model u_esr_tx_model (.i_clk(clk), .o_line(rx_line));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Clock at 50 MHz
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Watchdog so a hang still ends in the report
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
	task wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			n_errors++;
			wrap_up();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFF_FFFF);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, r & m, exp);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_regs();
		logic [31:0] r;
		logic        e;
		rdc("rsc reset", ESR_OFS_RSC, 32'h0);
		apb(1'b0, 8'h28, 32'h0, r, e);
		chk("unmapped data", r, 32'h0);
		chk("unmapped err", {31'h0, e}, 32'h1);
		wr(ESR_OFS_DIVH, 8'hA5);
		rdc("divisor high", ESR_OFS_DIVH, 32'hA5);
		wr(ESR_OFS_DIVH, 8'h00);
		wr(ESR_OFS_RXD, 8'h77);
		rdc("rxd read only", ESR_OFS_RXD, 32'h0);
	endtask
	task t_rx8();
		wr(ESR_OFS_TSC, 8'h04);
		wr(ESR_OFS_DIVL, 8'h00);
		wr(ESR_OFS_PIE, 8'h20);
		wr(ESR_OFS_GIC, 8'hC0);
		wr(ESR_OFS_RSC, 8'h90);
		u_esr_tx_model.send(9'h0A5, 8, 1'b1);
		chk("irq low", {31'h0, irq_lo}, 32'h1);
		rdc("status", ESR_OFS_RSC, 32'h90);
		rdc("data", ESR_OFS_RXD, 32'hA5);
		rdc("flag clear", ESR_OFS_PIF, 32'h0, 32'h20);
		// Wide divisor, tick of two clocks
		wr(ESR_OFS_TSC, 8'h00);
		wr(ESR_OFS_BDC, 8'h08);
		wr(ESR_OFS_DIVL, 8'h01);
		u_esr_tx_model.bclk = 32;
		u_esr_tx_model.send(9'h05A, 8, 1'b1);
		rdc("wide divisor", ESR_OFS_RXD, 32'h5A);
		u_esr_tx_model.bclk = 16;
		wr(ESR_OFS_BDC, 8'h00);
		wr(ESR_OFS_TSC, 8'h04);
		wr(ESR_OFS_DIVL, 8'h00);
		@(posedge clk) sleep <= 1'b1;
		u_esr_tx_model.send(9'h0C3, 8, 1'b1);
		rdc("asleep", ESR_OFS_PIF, 32'h0, 32'h20);
		@(posedge clk) sleep <= 1'b0;
	endtask
	task t_addr9();
		wr(ESR_OFS_RSC, 8'hD8);
		u_esr_tx_model.send(9'h055, 9, 1'b1);
		rdc("filtered", ESR_OFS_PIF, 32'h0, 32'h20);
		wr(ESR_OFS_IPR, 8'h20);
		u_esr_tx_model.send(9'h1C3, 9, 1'b1);
		chk("irq high", {30'h0, irq_hi, irq_lo}, 32'h2);
		rdc("ninth", ESR_OFS_RSC, 32'hD9);
		rdc("address", ESR_OFS_RXD, 32'hC3);
		wr(ESR_OFS_IPR, 8'h00);
	endtask
	task t_err();
		wr(ESR_OFS_RSC, 8'h90);
		u_esr_tx_model.send(9'h03C, 8, 1'b0);
		rdc("framing_error_flag", ESR_OFS_RSC, 32'h04, 32'h04);
		u_esr_tx_model.send(9'h011, 8, 1'b1);
		rdc("overrun_error_flag", ESR_OFS_RSC, 32'h02, 32'h02);
		wr(ESR_OFS_RSC, 8'h80);
		rdc("errors cleared", ESR_OFS_RSC, 32'h0, 32'h06);
		rdc("first kept", ESR_OFS_RXD, 32'h3C);
		wr(ESR_OFS_RSC, 8'h90);
	endtask
	task t_wake();
		logic [31:0] r;
		logic        e;
		wr(ESR_OFS_BDC, 8'h02);
		u_esr_tx_model.brk(12);
		chk("wake", {31'h0, wakeup}, 32'h1);
		rdc("wue auto clear", ESR_OFS_BDC, 32'h0, 32'h02);
		rdc("wake flag", ESR_OFS_PIF, 32'h20, 32'h20);
		rdc("no char", ESR_OFS_RSC, 32'h90);
		apb(1'b0, ESR_OFS_RXD, 32'h0, r, e);
		// The clear lands at the access edge; look once it has settled
		@(negedge clk);
		chk("wake cleared", {31'h0, wakeup}, 32'h0);
		rdc("flag idle", ESR_OFS_PIF, 32'h0, 32'h20);
	endtask

	// Main sequence
	initial begin
		n_errors = 0;
		num_checks = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_rx8();
		t_addr9();
		t_err();
		t_wake();
		wrap_up();
	end
endmodule

//--- tb/esr_tx_model.sv
// Far-end serial transmitter model driving the receive line
`timescale 1ns/1ps
module esr_tx_model (
	input  wire logic i_clk,  // Bench clock
	output logic      o_line  // Receive line, idle high
);
	int bclk = 16; // Clocks per bit, set by the bench to match the divisor
	initial o_line = 1'b1;
	// ------------------------------------------------------------
	// Senders
	// ------------------------------------------------------------
	// Start, data LSB first, stop, one idle bit; a low stop makes a framing fault
	task automatic send(input logic [8:0] d, input int nb, input logic stp);
		for (int i = -1; i <= nb; i++) begin
			@(posedge i_clk);
			o_line <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
			repeat (bclk - 1) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_line <= 1'b1;
		repeat (bclk - 1) @(posedge i_clk);
	endtask
	// All-zero wake character held long, then a long idle for start-up
	task automatic brk(input int nb);
		@(posedge i_clk);
		o_line <= 1'b0;
		repeat (nb * bclk) @(posedge i_clk);
		o_line <= 1'b1;
		repeat (2 * bclk) @(posedge i_clk);
	endtask
endmodule

//--- verilog/esr_pkg.sv
// Package: register map, field positions and reset values for the serial receiver
package esr_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ESR_OFS_GIC  = 8'h00; // global_interrupt_control
	localparam logic [7:0] ESR_OFS_PIF  = 8'h04; // peripheral_interrupt_flags
	localparam logic [7:0] ESR_OFS_PIE  = 8'h08; // peripheral_interrupt_enables
	localparam logic [7:0] ESR_OFS_IPR  = 8'h0C; // peripheral_interrupt_priorities
	localparam logic [7:0] ESR_OFS_RSC  = 8'h10; // receive_status_control
	localparam logic [7:0] ESR_OFS_RXD  = 8'h14; // receive_data
	localparam logic [7:0] ESR_OFS_TSC  = 8'h18; // transmit_status_control
	localparam logic [7:0] ESR_OFS_BDC  = 8'h1C; // baud_control
	localparam logic [7:0] ESR_OFS_DIVH = 8'h20; // baud_divisor_high
	localparam logic [7:0] ESR_OFS_DIVL = 8'h24; // baud_divisor_low

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ESR_B_GIE   = 7; // global_interrupt_enable
	localparam int ESR_B_PERIPHERAL_INTERRUPT_ENABLE  = 6; // peripheral_interrupt_enable
	localparam int ESR_B_RCF   = 5; // receive_complete_flag / enable / priority
	localparam int ESR_B_SERIAL_PORT_ENABLE  = 7; // serial_port_enable
	localparam int ESR_B_RX9   = 6; // nine_bit_receive_select
	localparam int ESR_B_CONTINUOUS_RECEIVE_ENABLE  = 4; // continuous_receive_enable
	localparam int ESR_B_ADDRESS_DETECT_ENABLE = 3; // address_detect_enable
	localparam int ESR_B_FRAMING_ERROR_FLAG  = 2; // framing_error_flag
	localparam int ESR_B_OVERRUN_ERROR_FLAG  = 1; // overrun_error_flag
	localparam int ESR_B_RECEIVED_NINTH_BIT  = 0; // received_ninth_bit
	localparam int ESR_B_SYNC  = 4; // clocked-mode select
	localparam int ESR_B_HIGH_SPEED_SELECT  = 2; // high_speed_select
	localparam int ESR_B_IDLE  = 6; // receiver idle status
	localparam int ESR_B_WIDE_DIVISOR_SELECT = 3; // wide_divisor_select
	localparam int ESR_B_WUE   = 1; // wakeup_enable

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] ESR_RST_BYTE = 8'h00; // All control bytes clear
	localparam logic [1:0] ESR_PRE_SLOW = 2'h3;  // Prescale minus one, low speed
	localparam logic [3:0] ESR_OVS_LAST = 4'hF;  // Last of sixteen ticks per bit
	localparam logic [3:0] ESR_OVS_MID  = 4'h9;  // Tick that ends the 7-8-9 vote
	localparam logic [3:0] ESR_BITS_8   = 4'h8;  // Data bits, 8-bit mode
	localparam logic [3:0] ESR_BITS_9   = 4'h9;  // Data bits, 9-bit mode

	// Receiver states
	typedef enum logic [1:0] {ESR_IDLE, ESR_START, ESR_DATA, ESR_STOP} esr_state_t;
endpackage

//--- verilog/esr_rx.sv
// Asynchronous serial receiver with address detect and wake-up, APB register slave
`timescale 1ns/1ps
module esr_rx
	import esr_pkg::*;
(
	input  wire logic        i_sys_clk, // System clock, 50 MHz
	input  wire logic        i_rst_n,   // Synchronous reset, active low
	input  wire logic        i_psel,    // APB select
	input  wire logic        i_penable, // APB access phase
	input  wire logic        i_pwrite,  // APB write
	input  wire logic [7:0]  i_paddr,   // APB byte address
	input  wire logic [31:0] i_pwdata,  // APB write data
	output logic      [31:0] o_prdata,  // APB read data, registered
	output logic             o_pready,  // APB ready
	output logic             o_pslverr, // APB error, unmapped address
	input  wire logic        i_sleep,   // Processor asleep
	input  wire logic        i_rx_line, // receive_line
	output logic             o_irq_high,// High priority receive interrupt
	output logic             o_irq_low, // Low priority receive interrupt
	output logic             o_wakeup   // Wake event pending
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [1:0]  gic_q;      // {global, peripheral} enables
	logic        receive_interrupt_enable_q;     // receive_interrupt_enable
	logic        receive_priority_select_q;     // receive_priority_select
	logic        serial_port_enable_q;     // serial_port_enable
	logic        rx9_q;      // nine_bit_receive_select
	logic        continuous_receive_enable_q;     // continuous_receive_enable
	logic        address_detect_enable_q;    // address_detect_enable
	logic        sync_q;     // Clocked-mode select
	logic        high_speed_select_q;     // high_speed_select
	logic        wide_divisor_select_q;    // wide_divisor_select
	logic        wue_q;      // wakeup_enable
	logic [7:0]  divh_q;     // baud_divisor_high
	logic [7:0]  divl_q;     // baud_divisor_low
	logic [7:0]  rxd_q;      // Buffered character, low byte
	logic        received_ninth_bit_q;     // Buffered ninth bit
	logic        framing_error_flag_q;     // framing_error_flag
	logic        overrun_error_flag_q;     // overrun_error_flag
	logic        full_q;     // Buffer holds an unread character
	logic        wake_q;     // Wake event pending
	logic        woke_q;     // Falling edge seen, waiting for rise
	logic [31:0] rdata_q;
	logic        line_q;     // Previous line level for edges

	// Receiver datapath
	esr_state_t  state_q;
	logic [1:0]  pre_q;      // Low-speed prescaler
	logic [15:0] brg_q;      // Baud counter
	logic [3:0]  ovs_q;      // Tick within bit
	logic [2:0]  smp_q;      // Sampling shifter
	logic [3:0]  bit_q;      // Data bits taken
	logic [8:0]  sh_q;       // Main receive shifter

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic        wr;         // Write access edge
	logic        rd_setup;   // Read setup edge
	logic        rd_data;    // Completed read of receive_data
	logic        mapped;     // Address hits a register
	logic        async_en;   // Port enabled in asynchronous mode
	logic        rx_run;     // Receiver allowed to run
	logic        tick;       // One sixteenth of a bit
	logic        vote;       // Majority of three samples
	logic        fall;       // Line fell
	logic        rise;       // Line rose
	logic        done;       // Character complete
	logic        keep;       // Character passes the address filter
	logic        nine;       // Nine data bits per character
	logic [15:0] div;
	logic [1:0]  pre_max;

	// Registers change on the access edge, one per transfer
	assign wr       = i_psel & i_penable & i_pwrite;
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
	assign rd_data  = i_psel & i_penable & ~i_pwrite & (i_paddr == ESR_OFS_RXD);
	assign mapped   = (i_paddr == ESR_OFS_GIC) | (i_paddr == ESR_OFS_PIF)
		| (i_paddr == ESR_OFS_PIE) | (i_paddr == ESR_OFS_IPR)
		| (i_paddr == ESR_OFS_RSC) | (i_paddr == ESR_OFS_RXD)
		| (i_paddr == ESR_OFS_TSC) | (i_paddr == ESR_OFS_BDC)
		| (i_paddr == ESR_OFS_DIVH) | (i_paddr == ESR_OFS_DIVL);
	// Every register answers at once, so the access phase never stretches
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~mapped;
	assign o_prdata  = rdata_q;

	// Mode qualification
	// Any disqualifier holds the receiver idle and its baud counter cleared
	assign async_en = serial_port_enable_q & ~sync_q;
	assign rx_run   = async_en & ~i_sleep & ~wue_q & continuous_receive_enable_q & ~overrun_error_flag_q;
	assign fall     = line_q & ~i_rx_line;
	assign rise     = ~line_q & i_rx_line;
	assign nine     = rx9_q;

	// Divisor: high byte used only in wide mode
	// Trade-off: in wide mode both speed modes share one x16 tick
	assign div     = wide_divisor_select_q ? {divh_q, divl_q} : {8'h00, divl_q};
	assign pre_max = (~high_speed_select_q & ~wide_divisor_select_q) ? ESR_PRE_SLOW : 2'h0;

	// Majority of the last three samples
	assign vote = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);

	// ----------------------------------------------------------------
	// Baud generator: one tick per sixteenth of a bit
	// ----------------------------------------------------------------
	// Held in reset while not running so each frame starts phase aligned
	// Limitation: the divisor is used live; changing it inside a frame
	// shifts the sampling point of the remaining bits
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !rx_run || state_q == ESR_IDLE) begin
			pre_q <= 2'h0;
			brg_q <= 16'h0000;
		end else if (pre_q != pre_max) begin
			pre_q <= pre_q + 2'h1;
		end else begin
			pre_q <= 2'h0;
			brg_q <= (brg_q == div) ? 16'h0000 : brg_q + 16'h0001;
		end
	end
	assign tick = rx_run && state_q != ESR_IDLE && pre_q == pre_max && brg_q == div;

	// ----------------------------------------------------------------
	// Receive state machine
	// ----------------------------------------------------------------
	// Held idle whenever reception is disabled, so a frame cut by sleep,
	// wake enable or overrun restarts cleanly at the next start edge
	assign done = tick && state_q == ESR_STOP && ovs_q == ESR_OVS_MID;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !rx_run) begin
			state_q <= ESR_IDLE;
			ovs_q   <= 4'h0;
			smp_q   <= 3'h7;
			bit_q   <= 4'h0;
			sh_q    <= 9'h000;
		end else begin
			if (tick) begin
				smp_q <= {smp_q[1:0], i_rx_line};
				ovs_q <= ovs_q + 4'h1;
			end
			unique case (state_q)
				ESR_IDLE: begin
					ovs_q <= 4'h0;
					bit_q <= 4'h0;
					if (fall) begin
						state_q <= ESR_START;
					end
				end
				ESR_START: begin
					// A high vote mid-bit was a glitch, not a start bit
					if (tick && ovs_q == ESR_OVS_MID && vote) begin
						state_q <= ESR_IDLE;
					end else if (tick && ovs_q == ESR_OVS_LAST) begin
						state_q <= ESR_DATA;
					end
				end
				ESR_DATA: begin
					if (tick && ovs_q == ESR_OVS_MID) begin
						sh_q  <= {vote, sh_q[8:1]};
						bit_q <= bit_q + 4'h1;
					end
					if (tick && ovs_q == ESR_OVS_LAST
						&& bit_q == (nine ? ESR_BITS_9 : ESR_BITS_8)) begin
						state_q <= ESR_STOP;
					end
				end
				ESR_STOP: begin
					// Finish mid stop bit so a close next start is not missed
					if (done) begin
						state_q <= ESR_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receive buffer and flags
	// ----------------------------------------------------------------
	// One-deep buffer: a character completing before the read is lost and
	// raises overrun, so software must read within one character time
	// Ninth bit is sh_q[8] in 9-bit mode; 8-bit data sits one place higher
	logic [7:0] cap_data;
	logic       cap_ninth;
	assign cap_data  = nine ? sh_q[7:0] : sh_q[8:1];
	assign cap_ninth = nine & sh_q[8];
	assign keep      = ~(address_detect_enable_q & nine) | cap_ninth;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rxd_q  <= 8'h00;
			received_ninth_bit_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			full_q <= 1'b0;
		end else if (done && keep && (!full_q || rd_data)) begin
			// New character wins over a same-cycle read
			rxd_q  <= cap_data;
			received_ninth_bit_q <= cap_ninth;
			framing_error_flag_q <= ~vote;
			full_q <= 1'b1;
		end else begin
			if (rd_data) begin
				full_q <= 1'b0;
			end
			if (!continuous_receive_enable_q) begin
				framing_error_flag_q <= 1'b0;
			end
		end
	end

	// Overrun: a kept character finds the buffer still full
	// Reception stops while overrun stands, so nothing more can be lost
	// before software clears the continuous enable
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !continuous_receive_enable_q) begin
			overrun_error_flag_q <= 1'b0;
		end else if (done && keep && full_q && !rd_data) begin
			overrun_error_flag_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Wake-up detection
	// ----------------------------------------------------------------
	// Line history runs even in sleep; wake watching needs no baud clock
	// Resets to the idle-high level so no false fall follows reset
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			line_q <= 1'b1;
		end else begin
			line_q <= i_rx_line;
		end
	end

	// Pending flag and armed state are apart: a data read clears the flag
	// while the enable still waits for the line to rise
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			wake_q <= 1'b0;
			woke_q <= 1'b0;
		end else begin
			if (wue_q && async_en && !woke_q && fall) begin
				wake_q <= 1'b1;
				woke_q <= 1'b1;
			end else if (rd_data) begin
				wake_q <= 1'b0;
			end
			if (woke_q && rise) begin
				woke_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers, APB writes
	// ----------------------------------------------------------------
	// Read-only fields and unmapped offsets ignore writes
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			gic_q   <= 2'h0;
			receive_interrupt_enable_q  <= 1'b0;
			receive_priority_select_q  <= 1'b0;
			serial_port_enable_q  <= 1'b0;
			rx9_q   <= 1'b0;
			continuous_receive_enable_q  <= 1'b0;
			address_detect_enable_q <= 1'b0;
			sync_q  <= 1'b0;
			high_speed_select_q  <= 1'b0;
			wide_divisor_select_q <= 1'b0;
			divh_q  <= ESR_RST_BYTE;
			divl_q  <= ESR_RST_BYTE;
		end else if (wr) begin
			unique case (i_paddr)
				ESR_OFS_GIC: gic_q <= i_pwdata[ESR_B_GIE:ESR_B_PERIPHERAL_INTERRUPT_ENABLE];
				ESR_OFS_PIE: receive_interrupt_enable_q <= i_pwdata[ESR_B_RCF];
				ESR_OFS_IPR: receive_priority_select_q <= i_pwdata[ESR_B_RCF];
				ESR_OFS_RSC: begin
					serial_port_enable_q  <= i_pwdata[ESR_B_SERIAL_PORT_ENABLE];
					rx9_q   <= i_pwdata[ESR_B_RX9];
					continuous_receive_enable_q  <= i_pwdata[ESR_B_CONTINUOUS_RECEIVE_ENABLE];
					address_detect_enable_q <= i_pwdata[ESR_B_ADDRESS_DETECT_ENABLE];
				end
				ESR_OFS_TSC: begin
					sync_q <= i_pwdata[ESR_B_SYNC];
					high_speed_select_q <= i_pwdata[ESR_B_HIGH_SPEED_SELECT];
				end
				ESR_OFS_BDC:  wide_divisor_select_q <= i_pwdata[ESR_B_WIDE_DIVISOR_SELECT];
				ESR_OFS_DIVH: divh_q <= i_pwdata[7:0];
				ESR_OFS_DIVL: divl_q <= i_pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Wake enable: the rising edge clear wins over a same-cycle write
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			wue_q <= 1'b0;
		end else if (woke_q && rise) begin
			wue_q <= 1'b0;
		end else if (wr && i_paddr == ESR_OFS_BDC) begin
			wue_q <= i_pwdata[ESR_B_WUE];
		end
	end

	// ----------------------------------------------------------------
	// Read data, captured in the setup phase
	// ----------------------------------------------------------------
	// Captured one cycle early so the data output comes from a flip-flop
	// and stands for the whole access phase
	logic receive_complete_flag;
	assign receive_complete_flag = full_q | wake_q;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			rdata_q <= 32'h0000_0000;
			unique case (i_paddr)
				ESR_OFS_GIC: rdata_q[ESR_B_GIE:ESR_B_PERIPHERAL_INTERRUPT_ENABLE] <= gic_q;
				ESR_OFS_PIF: rdata_q[ESR_B_RCF] <= receive_complete_flag;
				ESR_OFS_PIE: rdata_q[ESR_B_RCF] <= receive_interrupt_enable_q;
				ESR_OFS_IPR: rdata_q[ESR_B_RCF] <= receive_priority_select_q;
				ESR_OFS_RSC: rdata_q[7:0] <= {serial_port_enable_q, rx9_q, 1'b0, continuous_receive_enable_q, address_detect_enable_q,
					framing_error_flag_q, overrun_error_flag_q, received_ninth_bit_q};
				ESR_OFS_RXD: rdata_q[7:0] <= rxd_q;
				ESR_OFS_TSC: rdata_q[7:0] <= {3'h0, sync_q, 1'b0, high_speed_select_q, 2'h0};
				ESR_OFS_BDC: rdata_q[7:0] <= {1'b0, state_q == ESR_IDLE, 2'h0,
					wide_divisor_select_q, 1'b0, wue_q, 1'b0};
				ESR_OFS_DIVH: rdata_q[7:0] <= divh_q;
				ESR_OFS_DIVL: rdata_q[7:0] <= divl_q;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupt requests
	// ----------------------------------------------------------------
	// High priority needs only the global enable; low also needs peripheral
	// Both requests are levels that stand until the flag clears
	assign o_irq_high = receive_complete_flag & receive_interrupt_enable_q & receive_priority_select_q & gic_q[1];
	assign o_irq_low  = receive_complete_flag & receive_interrupt_enable_q & ~receive_priority_select_q & gic_q[1] & gic_q[0];
	assign o_wakeup   = wake_q;
endmodule
